// ==== mac_pkg.sv ====
/*
 Constants of the memory access attribute checker: register map, attribute
 field layout, encodings and reset values. Assumes a 32-bit AXI4-Lite bus.
*/
package mac_pkg;
	localparam int          NUM_REGIONS      = 4;
	localparam logic [7:0]  OFF_CTRL         = 8'h00;
	localparam logic [7:0]  OFF_STATUS       = 8'h04;
	localparam logic [7:0]  OFF_FAULT_ADDR   = 8'h08;
	localparam logic [7:0]  OFF_DEFAULT_ATTR = 8'h0C;
	localparam logic [3:0]  REGION_FIRST     = 4'h1;
	localparam logic [3:0]  OFF_SUB_BASE     = 4'h0;
	localparam logic [3:0]  OFF_SUB_LIMIT    = 4'h4;
	localparam logic [3:0]  OFF_SUB_ATTR     = 4'h8;
	localparam int          CTRL_EN_BIT      = 0;
	localparam int          CTRL_PRIVX_BIT   = 1;
	localparam int          ATTR_SHARE_BIT   = 2;
	localparam int          ATTR_CACHE_BIT   = 3;
	localparam int          ATTR_DPERM_LO    = 4;
	localparam int          ATTR_XPERM_LO    = 6;
	localparam int          ATTR_REN_BIT     = 8;
	localparam logic [1:0]  MT_NORMAL        = 2'h0;
	localparam logic [1:0]  MT_DEVICE        = 2'h1;
	localparam logic [1:0]  MT_STRONG        = 2'h2;
	localparam logic [1:0]  PERM_NONE        = 2'h0;
	localparam logic [1:0]  PERM_PRIV        = 2'h1;
	localparam logic [1:0]  PERM_ALL         = 2'h2;
	localparam logic [1:0]  SIZE_BYTE        = 2'h0;
	localparam logic [1:0]  SIZE_HALF        = 2'h1;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;
	localparam logic [1:0]  RESP_DECERR      = 2'h3;
	localparam logic [3:0]  KIND_NONE        = 4'h0;
	localparam logic [3:0]  KIND_DATA        = 4'h1;
	localparam logic [3:0]  KIND_EXEC        = 4'h2;
	localparam logic [3:0]  KIND_MISUSE      = 4'h3;
	localparam logic [3:0]  KIND_REGPRIV     = 4'h4;
	localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
	localparam logic [31:0] DEFAULT_RESET    = 32'h0000_00A4;
	localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
	typedef enum logic [1:0] {CHK_IDLE, CHK_ISSUE} chk_state_type;
endpackage

// ==== mac_checker.sv ====
/*
 Memory access attribute checker: region lookup, permission check and one-beat
 issue of each pipeline request that passes the checks to the memory system, plus AXI4-Lite registers.
 Assumes the pipeline holds a request until REQ_ACK_O and the memory side holds
 MEM_READY_I semantics of a valid/ready handshake.
*/
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module mac_checker
	import mac_pkg::*;
(
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_I,
	input  wire logic        REQ_VALID_I,
	input  wire logic [31:0] REQ_ADDR_I,
	input  wire logic        REQ_WRITE_I,
	input  wire logic [1:0]  REQ_SIZE_I,
	input  wire logic [31:0] REQ_WDATA_I,
	input  wire logic        REQ_FETCH_I,
	input  wire logic        REQ_PRIV_I,
	input  wire logic        REQ_SPEC_I,
	input  wire logic        REQ_MULTI_I,
	input  wire logic        REQ_LAST_I,
	input  wire logic        REQ_LOADS_PC_I,
	input  wire logic        EXC_TAKEN_I,
	output logic             REQ_ACK_O,
	output logic [31:0]      REQ_RDATA_O,
	output logic             FAULT_O,
	output logic             EXEC_ERR_O,
	output logic             DEFER_O,
	output logic             ABANDON_O,
	output logic             INT_HOLD_O,
	output logic             MEM_VALID_O,
	input  wire logic        MEM_READY_I,
	output logic [31:0]      MEM_ADDR_O,
	output logic             MEM_WRITE_O,
	output logic [1:0]       MEM_SIZE_O,
	output logic [31:0]      MEM_WDATA_O,
	output logic [1:0]       MEM_TYPE_O,
	output logic             MEM_SHARE_O,
	output logic             MEM_CACHE_O,
	output logic             MEM_FETCH_O,
	input  wire logic [31:0] MEM_RDATA_I,
	input  wire logic [7:0]  AWADDR_I,
	input  wire logic [2:0]  AWPROT_I,
	input  wire logic        AWVALID_I,
	output logic             AWREADY_O,
	input  wire logic [31:0] WDATA_I,
	input  wire logic [3:0]  WSTRB_I,
	input  wire logic        WVALID_I,
	output logic             WREADY_O,
	output logic [1:0]       BRESP_O,
	output logic             BVALID_O,
	input  wire logic        BREADY_I,
	input  wire logic [7:0]  ARADDR_I,
	input  wire logic [2:0]  ARPROT_I,
	input  wire logic        ARVALID_I,
	output logic             ARREADY_O,
	output logic [31:0]      RDATA_O,
	output logic [1:0]       RRESP_O,
	output logic             RVALID_O,
	input  wire logic        RREADY_I
);
	chk_state_type state_q;
	logic [31:0]   ctrl_q, default_q, fault_addr_q;
	logic [31:0]   base_q [NUM_REGIONS];
	logic [31:0]   limit_q [NUM_REGIONS];
	logic [31:0]   attr_q [NUM_REGIONS];
	logic [7:0]    fault_cnt_q, aw_addr_q;
	logic [3:0]    fault_kind_q, w_strb_q;
	logic          aw_have_q, w_have_q, aw_priv_q;
	logic [31:0]   w_data_q, rd_word;
	logic          rd_hit, wr_hit, do_write, reg_fault;
	logic          take, chk_fault, chk_exec_bad, chk_defer, chk_abandon, chk_periph, chk_misalign, chk_perm_ok;
	logic          priv_eff;
	logic [31:0]   chk_attr;
	logic [1:0]    chk_type, chk_perm;
	logic          ack_q, fault_q, exec_err_q, defer_q, abandon_q, int_hold_q;
	logic          mem_valid_q, mem_write_q, mem_share_q, mem_cache_q, mem_fetch_q;
	logic [31:0]   mem_addr_q, mem_wdata_q, rdata_q, req_rdata_q;
	logic [1:0]    mem_size_q, mem_type_q, bresp_q, rresp_q;
	logic          awready_q, wready_q, bvalid_q, arready_q, rvalid_q;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic reg_decode(input logic [7:0] a);
		logic ok;
		ok = (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_FAULT_ADDR) || (a == OFF_DEFAULT_ATTR);
		if ((a[7:4] >= REGION_FIRST) && (a[7:4] < REGION_FIRST + 4'(NUM_REGIONS)) && (a[3:0] <= OFF_SUB_ATTR)
				&& (a[1:0] == 2'h0)) begin
			ok = 1'b1;
		end
		return ok;
	endfunction

	// Region lookup; the highest numbered enabled region wins an overlap
	always_comb begin
		chk_attr = default_q;
		if (ctrl_q[CTRL_EN_BIT]) begin
			for (int i = 0; i < NUM_REGIONS; i++) begin
				if (attr_q[i][ATTR_REN_BIT] && (REQ_ADDR_I >= base_q[i]) && (REQ_ADDR_I <= limit_q[i])) begin
					chk_attr = attr_q[i];
				end
			end
		end
		chk_type     = chk_attr[1:0];
		chk_periph   = (chk_type != MT_NORMAL);
		priv_eff     = !ctrl_q[CTRL_PRIVX_BIT] || REQ_PRIV_I;
		chk_perm     = REQ_FETCH_I ? chk_attr[ATTR_XPERM_LO +: 2] : chk_attr[ATTR_DPERM_LO +: 2];
		chk_perm_ok  = (chk_perm == PERM_ALL) || ((chk_perm == PERM_PRIV) && priv_eff);
		chk_misalign = (REQ_SIZE_I == SIZE_HALF) ? REQ_ADDR_I[0] :
			(REQ_SIZE_I == SIZE_BYTE) ? 1'b0 : (REQ_ADDR_I[1:0] != 2'h0);
		// Peripheral memory is never fetched, whatever its execute field says
		chk_exec_bad = REQ_FETCH_I && (chk_periph || !chk_perm_ok);
		// Misuse of peripheral memory is stopped here rather than left unpredictable
		chk_fault    = chk_exec_bad || (!REQ_FETCH_I && (!chk_perm_ok
			|| (chk_periph && (chk_misalign || REQ_LOADS_PC_I))));
		chk_defer    = !chk_fault && !REQ_FETCH_I && REQ_SPEC_I && (chk_type == MT_STRONG);
		// Only Normal beats are abandoned: peripheral beats must not repeat
		chk_abandon  = !chk_fault && !chk_defer && EXC_TAKEN_I && REQ_MULTI_I && !chk_periph;
	end

	assign take = (state_q == CHK_IDLE) && REQ_VALID_I && !ack_q;

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			state_q <= CHK_IDLE;
		end else begin
			case (state_q)
				CHK_IDLE: begin
					if (take && !chk_fault && !chk_defer && !chk_abandon) begin
						state_q <= CHK_ISSUE;
					end
				end
				CHK_ISSUE: begin
					if (MEM_READY_I) begin
						state_q <= CHK_IDLE;
					end
				end
				default: state_q <= CHK_IDLE;
			endcase
		end
	end

	// One request becomes at most one beat at its own size; nothing is merged
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			mem_valid_q <= 1'b0;
			mem_addr_q  <= ZERO_WORD;
			mem_wdata_q <= ZERO_WORD;
			mem_write_q <= 1'b0;
			mem_size_q  <= SIZE_BYTE;
			mem_type_q  <= MT_NORMAL;
			mem_share_q <= 1'b0;
			mem_cache_q <= 1'b0;
			mem_fetch_q <= 1'b0;
		end else if (take && !chk_fault && !chk_defer && !chk_abandon) begin
			mem_valid_q <= 1'b1;
			mem_addr_q  <= REQ_ADDR_I;
			mem_wdata_q <= REQ_WDATA_I;
			mem_write_q <= REQ_WRITE_I;
			mem_size_q  <= REQ_SIZE_I;
			mem_type_q  <= chk_type;
			mem_share_q <= chk_attr[ATTR_SHARE_BIT] || (chk_type == MT_STRONG);
			mem_cache_q <= chk_attr[ATTR_CACHE_BIT] && !chk_periph;
			mem_fetch_q <= REQ_FETCH_I;
		end else if (mem_valid_q && MEM_READY_I) begin
			mem_valid_q <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			ack_q       <= 1'b0;
			exec_err_q  <= 1'b0;
			defer_q     <= 1'b0;
			abandon_q   <= 1'b0;
			req_rdata_q <= ZERO_WORD;
		end else begin
			ack_q      <= (take && (chk_fault || chk_defer || chk_abandon)) || (mem_valid_q && MEM_READY_I);
			exec_err_q <= take && chk_exec_bad;
			defer_q    <= take && chk_defer;
			abandon_q  <= take && chk_abandon;
			if (mem_valid_q && MEM_READY_I) begin
				req_rdata_q <= MEM_RDATA_I;
			end
		end
	end

	// Interrupts are held off inside a multi-word sequence on peripheral memory
	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			int_hold_q <= 1'b0;
		end else if (take) begin
			int_hold_q <= !chk_fault && chk_periph && REQ_MULTI_I && !REQ_LAST_I;
		end
	end

	assign reg_fault = do_write && !aw_priv_q;

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			fault_q      <= 1'b0;
			fault_cnt_q  <= 8'h00;
			fault_kind_q <= KIND_NONE;
			fault_addr_q <= ZERO_WORD;
		end else begin
			fault_q <= (take && chk_fault) || reg_fault || (ARVALID_I && arready_q && !ARPROT_I[0]);
			if (take && chk_fault) begin
				fault_cnt_q  <= fault_cnt_q + 8'h01;
				fault_addr_q <= REQ_ADDR_I;
				fault_kind_q <= chk_exec_bad ? KIND_EXEC : (chk_perm_ok ? KIND_MISUSE : KIND_DATA);
			end else if (reg_fault || (ARVALID_I && arready_q && !ARPROT_I[0])) begin
				fault_cnt_q  <= fault_cnt_q + 8'h01;
				fault_kind_q <= KIND_REGPRIV;
			end
		end
	end

	// AXI4-Lite write: address and data are taken in either order
	assign do_write = aw_have_q && w_have_q && !bvalid_q;
	assign wr_hit   = reg_decode(aw_addr_q);

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			aw_priv_q <= 1'b0;
			w_data_q  <= ZERO_WORD;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (AWVALID_I && awready_q) begin
				awready_q <= 1'b0;
				aw_have_q <= 1'b1;
				aw_addr_q <= AWADDR_I;
				aw_priv_q <= AWPROT_I[0];
			end
			if (WVALID_I && wready_q) begin
				wready_q <= 1'b0;
				w_have_q <= 1'b1;
				w_data_q <= WDATA_I;
				w_strb_q <= WSTRB_I;
			end
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= !aw_priv_q ? RESP_SLVERR : (wr_hit ? RESP_OKAY : RESP_DECERR);
			end else if (bvalid_q && BREADY_I) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			ctrl_q    <= CTRL_RESET;
			default_q <= DEFAULT_RESET;
			for (int i = 0; i < NUM_REGIONS; i++) begin
				base_q[i]  <= ZERO_WORD;
				limit_q[i] <= ZERO_WORD;
				attr_q[i]  <= ZERO_WORD;
			end
		end else if (do_write && aw_priv_q) begin
			if (aw_addr_q == OFF_CTRL) begin
				ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
			end
			if (aw_addr_q == OFF_DEFAULT_ATTR) begin
				default_q <= merge(default_q, w_data_q, w_strb_q);
			end
			for (int i = 0; i < NUM_REGIONS; i++) begin
				if (wr_hit && (aw_addr_q[7:4] == REGION_FIRST + 4'(i))) begin
					if (aw_addr_q[3:0] == OFF_SUB_BASE) begin
						base_q[i] <= merge(base_q[i], w_data_q, w_strb_q);
					end
					if (aw_addr_q[3:0] == OFF_SUB_LIMIT) begin
						limit_q[i] <= merge(limit_q[i], w_data_q, w_strb_q);
					end
					if (aw_addr_q[3:0] == OFF_SUB_ATTR) begin
						attr_q[i] <= merge(attr_q[i], w_data_q, w_strb_q);
					end
				end
			end
		end
	end

	always_comb begin
		rd_hit  = reg_decode(ARADDR_I);
		rd_word = ZERO_WORD;
		case (ARADDR_I)
			OFF_CTRL:         rd_word = ctrl_q;
			OFF_STATUS:       rd_word = {16'h0000, fault_cnt_q, 3'h0, (state_q == CHK_ISSUE), fault_kind_q};
			OFF_FAULT_ADDR:   rd_word = fault_addr_q;
			OFF_DEFAULT_ATTR: rd_word = default_q;
			default: begin
				for (int i = 0; i < NUM_REGIONS; i++) begin
					if (rd_hit && (ARADDR_I[7:4] == REGION_FIRST + 4'(i))) begin
						rd_word = (ARADDR_I[3:0] == OFF_SUB_BASE) ? base_q[i] :
							(ARADDR_I[3:0] == OFF_SUB_LIMIT) ? limit_q[i] : attr_q[i];
					end
				end
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (RST_I) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= ZERO_WORD;
			rresp_q   <= RESP_OKAY;
		end else if (ARVALID_I && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= (ARPROT_I[0] && rd_hit) ? rd_word : ZERO_WORD;
			rresp_q   <= !ARPROT_I[0] ? RESP_SLVERR : (rd_hit ? RESP_OKAY : RESP_DECERR);
		end else if (rvalid_q && RREADY_I) begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	assign REQ_ACK_O   = ack_q;
	assign REQ_RDATA_O = req_rdata_q;
	assign FAULT_O     = fault_q;
	assign EXEC_ERR_O  = exec_err_q;
	assign DEFER_O     = defer_q;
	assign ABANDON_O   = abandon_q;
	assign INT_HOLD_O  = int_hold_q;
	assign MEM_VALID_O = mem_valid_q;
	assign MEM_ADDR_O  = mem_addr_q;
	assign MEM_WRITE_O = mem_write_q;
	assign MEM_SIZE_O  = mem_size_q;
	assign MEM_WDATA_O = mem_wdata_q;
	assign MEM_TYPE_O  = mem_type_q;
	assign MEM_SHARE_O = mem_share_q;
	assign MEM_CACHE_O = mem_cache_q;
	assign MEM_FETCH_O = mem_fetch_q;
	assign AWREADY_O   = awready_q;
	assign WREADY_O    = wready_q;
	assign BVALID_O    = bvalid_q;
	assign BRESP_O     = bresp_q;
	assign ARREADY_O   = arready_q;
	assign RVALID_O    = rvalid_q;
	assign RDATA_O     = rdata_q;
	assign RRESP_O     = rresp_q;

	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);

	sequence good_take;
		take && !chk_fault && !chk_defer && !chk_abandon;
	endsequence
	sequence beat_done;
		mem_valid_q && MEM_READY_I;
	endsequence

	no_spec_strong_a: assert property (take && chk_defer |=> !mem_valid_q && defer_q && ack_q)
		else $error("speculative strongly-ordered access reached the bus");
	strong_shared_a: assert property (mem_valid_q && (mem_type_q == MT_STRONG) |-> mem_share_q && !mem_cache_q)
		else $error("strongly-ordered beat cached or not shareable");
	one_beat_a: assert property (beat_done |=> !mem_valid_q && ack_q ##1 !ack_q)
		else $error("request produced more than one beat");
	size_kept_a: assert property (good_take |=> mem_valid_q && (mem_size_q == $past(REQ_SIZE_I))
		&& (mem_addr_q == $past(REQ_ADDR_I)))
		else $error("beat size or address differs from request");
	beat_held_a: assert property (mem_valid_q && !MEM_READY_I |=> mem_valid_q && $stable(mem_addr_q)
		&& $stable(mem_size_q))
		else $error("pending beat changed before it was taken");
	fault_no_bus_a: assert property (take && chk_fault |=> fault_q && ack_q && !mem_valid_q)
		else $error("faulting access was not stopped before the bus");
	fetch_normal_a: assert property (mem_valid_q && mem_fetch_q |-> (mem_type_q == MT_NORMAL))
		else $error("fetch issued to peripheral memory");
	exec_err_a: assert property (take && chk_exec_bad |=> exec_err_q && fault_q)
		else $error("forbidden fetch gave no execution error");
	reg_priv_a: assert property (do_write && !aw_priv_q |=> bvalid_q && (bresp_q == RESP_SLVERR) && fault_q)
		else $error("unprivileged register write not refused");
	priv_ext_a: assert property (take && !ctrl_q[CTRL_PRIVX_BIT] && !REQ_FETCH_I
		&& (chk_attr[ATTR_DPERM_LO +: 2] == PERM_PRIV) && !chk_periph |=> !fault_q)
		else $error("access faulted as unprivileged without privilege extension");
	abandon_a: assert property (take && chk_abandon |=> abandon_q && ack_q ##1 !mem_valid_q)
		else $error("abandoned beat was issued");
endmodule

// ==== mem_model.sv ====
/*
 Memory-side partner of the attribute checker: answers each beat promptly or
 slowly in turn and records the last beat taken. Assumes a valid/ready beat.
*/
`timescale 1ns/10ps
module mem_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        valid_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [1:0]  size_i,
	input  wire logic [1:0]  type_i,
	input  wire logic        share_i,
	input  wire logic        cache_i,
	input  wire logic        fetch_i,
	output logic             ready_o,
	output logic [31:0]      rdata_o,
	output logic [31:0]      beats_o,
	output logic [31:0]      addr_o,
	output logic [6:0]       last_o
);
	logic [1:0] wait_q;
	logic       slow_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ready_o <= 1'b0;
			rdata_o <= 32'h0000_0000;
			beats_o <= 32'h0000_0000;
			addr_o <= 32'h0000_0000;
			last_o <= 7'h00;
			wait_q <= 2'h0;
			slow_q <= 1'b0;
		end else begin
			ready_o <= 1'b0;
			// Idle data bus toggles so a stale value is never mistaken for an answer
			rdata_o <= ~rdata_o;
			if (valid_i && ready_o) begin
				beats_o <= beats_o + 32'h0000_0001;
				last_o <= {fetch_i, cache_i, share_i, type_i, size_i};
				addr_o <= addr_i;
				slow_q <= ~slow_q;
				wait_q <= 2'h0;
			end else if (valid_i) begin
				if (wait_q == (slow_q ? 2'h3 : 2'h0)) begin
					ready_o <= 1'b1;
					rdata_o <= addr_i ^ 32'h5A5A_0000;
				end else begin
					wait_q <= wait_q + 2'h1;
				end
			end
		end
	end
endmodule

// ==== testbench.sv ====
/*
 Self-checking bench of the attribute checker: AXI4-Lite register tasks and a
 pipeline request task. Assumes mem_model answers the memory side.
*/
`timescale 1ns/10ps
module testbench;
	import mac_pkg::*;
	logic        CORE_CLK_I, RST_I, REQ_VALID_I, REQ_WRITE_I, REQ_FETCH_I, REQ_PRIV_I, REQ_SPEC_I;
	logic        REQ_MULTI_I, REQ_LAST_I, REQ_LOADS_PC_I, EXC_TAKEN_I, REQ_ACK_O, FAULT_O, EXEC_ERR_O;
	logic        DEFER_O, ABANDON_O, INT_HOLD_O, MEM_VALID_O, MEM_READY_I, MEM_WRITE_O, MEM_SHARE_O;
	logic        MEM_CACHE_O, MEM_FETCH_O, AWVALID_I, AWREADY_O, WVALID_I, WREADY_O, BVALID_O, BREADY_I;
	logic        ARVALID_I, ARREADY_O, RVALID_O, RREADY_I;
	logic [31:0] REQ_ADDR_I, REQ_WDATA_I, REQ_RDATA_O, MEM_ADDR_O, MEM_WDATA_O, MEM_RDATA_I, WDATA_I, RDATA_O;
	logic [1:0]  REQ_SIZE_I, MEM_SIZE_O, MEM_TYPE_O, BRESP_O, RRESP_O;
	logic [7:0]  AWADDR_I, ARADDR_I;
	logic [2:0]  AWPROT_I, ARPROT_I;
	logic [3:0]  WSTRB_I;
	logic [31:0] beats, m_addr;
	logic [6:0]  m_last;
	logic [31:0] attr_tab [4] = '{32'h0000_01AA, 32'h0000_0111, 32'h0000_0148, 32'h0000_01A0};
	int          n_mismatch, samples_checked, cycles, n_fault, n_exec, n_defer, n_aband;

	mac_checker uut (.*);
	mem_model partner (
		.clk_i  (CORE_CLK_I),
		.rst_i  (RST_I),
		.valid_i(MEM_VALID_O),
		.addr_i (MEM_ADDR_O),
		.size_i (MEM_SIZE_O),
		.type_i (MEM_TYPE_O),
		.share_i(MEM_SHARE_O),
		.cache_i(MEM_CACHE_O),
		.fetch_i(MEM_FETCH_O),
		.ready_o(MEM_READY_I),
		.rdata_o(MEM_RDATA_I),
		.beats_o(beats),
		.addr_o (m_addr),
		.last_o (m_last)
	);

	initial begin
		CORE_CLK_I = 1'b0;
		forever #50 CORE_CLK_I = ~CORE_CLK_I;
	end

	// Pulses stand one cycle, so counting high cycles also checks their width
	always @(negedge CORE_CLK_I) begin
		n_fault += int'(FAULT_O === 1'b1);
		n_exec += int'(EXEC_ERR_O === 1'b1);
		n_defer += int'(DEFER_O === 1'b1);
		n_aband += int'(ABANDON_O === 1'b1);
	end

	always @(posedge CORE_CLK_I) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] p, input logic [1:0] er);
		logic [1:0] resp;
		bit         aw_go, w_go, b_go, done;
		done = 0;
		@(posedge CORE_CLK_I);
		{AWADDR_I, AWPROT_I, WDATA_I} <= {a, p, d};
		{AWVALID_I, WVALID_I, BREADY_I} <= 3'h7;
		for (int n = 0; n < 50 && !done; n++) begin
			@(negedge CORE_CLK_I);
			aw_go = AWVALID_I && AWREADY_O;
			w_go = WVALID_I && WREADY_O;
			b_go = BVALID_O && BREADY_I;
			resp = BRESP_O;
			@(posedge CORE_CLK_I);
			if (aw_go)
				AWVALID_I <= 1'b0;
			if (w_go)
				WVALID_I <= 1'b0;
			if (b_go) begin
				BREADY_I <= 1'b0;
				done = 1;
			end
		end
		check({31'h0, done}, 32'h0000_0001);
		check({30'h0, resp}, {30'h0, er});
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [2:0] p, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] data;
		logic [1:0]  resp;
		bit          ar_go, done;
		done = 0;
		@(posedge CORE_CLK_I);
		{ARADDR_I, ARPROT_I} <= {a, p};
		{ARVALID_I, RREADY_I} <= 2'h3;
		for (int n = 0; n < 50 && !done; n++) begin
			@(negedge CORE_CLK_I);
			ar_go = ARVALID_I && ARREADY_O;
			done = RVALID_O && RREADY_I;
			{data, resp} = {RDATA_O, RRESP_O};
			@(posedge CORE_CLK_I);
			if (ar_go)
				ARVALID_I <= 1'b0;
			if (done)
				RREADY_I <= 1'b0;
		end
		check({31'h0, done}, 32'h0000_0001);
		check(data, ed);
		check({30'h0, resp}, {30'h0, er});
	endtask

	// Flags: {exc, loads_pc, last, multi, spec, priv, fetch, write}
	// Outcome: 0 beat, 1 fault, 2 execution error, 3 deferred, 4 abandoned
	// Beat fields: {fetch, cache, share, type, size}
	task automatic do_req(input logic [31:0] a, input logic [1:0] sz, input logic [7:0] fl, input logic [2:0] ek,
		input logic [6:0] ex);
		int          f0, x0, d0, a0;
		logic [31:0] b0;
		bit          done;
		{f0, x0, d0, a0, b0, done} = {n_fault, n_exec, n_defer, n_aband, beats, 1'b0};
		@(posedge CORE_CLK_I);
		{REQ_ADDR_I, REQ_SIZE_I, REQ_WDATA_I} <= {a, sz, ~a};
		{EXC_TAKEN_I, REQ_LOADS_PC_I, REQ_LAST_I, REQ_MULTI_I, REQ_SPEC_I, REQ_PRIV_I, REQ_FETCH_I, REQ_WRITE_I} <= fl;
		REQ_VALID_I <= 1'b1;
		for (int n = 0; n < 50 && !done; n++) begin
			@(negedge CORE_CLK_I);
			done = (REQ_ACK_O === 1'b1);
			@(posedge CORE_CLK_I);
		end
		REQ_VALID_I <= 1'b0;
		check({31'h0, done}, 32'h0000_0001);
		check(beats - b0, 32'(ek == 3'h0));
		check(32'(n_fault - f0), 32'(ek == 3'h1 || ek == 3'h2));
		check(32'(n_exec - x0), 32'(ek == 3'h2));
		check(32'(n_defer - d0), 32'(ek == 3'h3));
		check(32'(n_aband - a0), 32'(ek == 3'h4));
		if (ek == 3'h0) begin
			check({25'h0, m_last}, {25'h0, ex});
			check(m_addr, a);
			// Beat fields hold until the next take, so direction and data are still on show
			check({31'h0, MEM_WRITE_O}, {31'h0, fl[0]});
			check(MEM_WDATA_O, ~a);
			if (!fl[0])
				check(REQ_RDATA_O, a ^ 32'h5A5A_0000);
		end
	endtask

	initial begin
		int f;
		RST_I = 1'b1;
		{REQ_VALID_I, REQ_WRITE_I, REQ_FETCH_I, REQ_PRIV_I, REQ_SPEC_I, REQ_MULTI_I, REQ_LAST_I} = '0;
		{REQ_LOADS_PC_I, EXC_TAKEN_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I} = '0;
		{REQ_ADDR_I, REQ_WDATA_I, WDATA_I, REQ_SIZE_I, AWADDR_I, ARADDR_I, AWPROT_I, ARPROT_I} = '0;
		WSTRB_I = 4'hF;
		repeat (8) @(posedge CORE_CLK_I);
		RST_I <= 1'b0;
		axi_rd(OFF_CTRL, 3'h1, CTRL_RESET, RESP_OKAY);
		axi_rd(OFF_DEFAULT_ATTR, 3'h1, DEFAULT_RESET, RESP_OKAY);
		axi_rd(8'hFC, 3'h1, ZERO_WORD, RESP_DECERR);
		f = n_fault;
		axi_rd(OFF_CTRL, 3'h0, ZERO_WORD, RESP_SLVERR);
		axi_wr(OFF_CTRL, 32'h0000_0003, 3'h0, RESP_SLVERR);
		check(32'(n_fault - f), 32'h0000_0002);
		axi_rd(OFF_CTRL, 3'h1, CTRL_RESET, RESP_OKAY);
		do_req(32'h6000_0010, 2'h2, 8'h00, 3'h0, 7'h12);
		$display("Test register access done");
		for (int i = 0; i < NUM_REGIONS; i++) begin
			axi_wr({4'(i + 1), OFF_SUB_BASE}, 32'(i + 4) << 28, 3'h1, RESP_OKAY);
			axi_wr({4'(i + 1), OFF_SUB_LIMIT}, (32'(i + 4) << 28) + 32'h0000_0FFF, 3'h1, RESP_OKAY);
			axi_wr({4'(i + 1), OFF_SUB_ATTR}, attr_tab[i], 3'h1, RESP_OKAY);
		end
		axi_rd({4'h4, OFF_SUB_ATTR}, 3'h1, 32'h0000_01A0, RESP_OKAY);
		axi_wr(OFF_CTRL, 32'h0000_0003, 3'h1, RESP_OKAY);
		$display("Test region setup done");
		// Every access stays inside one region, so no access straddles two types; only the word at 5000_0002 is misaligned
		do_req(32'h4000_0002, SIZE_HALF, 8'h05, 3'h0, 7'h19);
		do_req(32'h4000_0004, 2'h2, 8'h0C, 3'h3, 7'h00);
		do_req(32'h4000_0008, 2'h2, 8'h00, 3'h0, 7'h1A);
		do_req(32'h4000_0000, 2'h2, 8'h06, 3'h2, 7'h00);
		do_req(32'h5000_0000, 2'h2, 8'h00, 3'h1, 7'h00);
		do_req(32'h5000_0001, SIZE_BYTE, 8'h04, 3'h0, 7'h04);
		do_req(32'h5000_0002, 2'h2, 8'h04, 3'h1, 7'h00);
		do_req(32'h5000_0008, 2'h2, 8'h54, 3'h1, 7'h00);
		// Multi-access to peripheral memory is only ever a read here, never a restartable write
		do_req(32'h5000_000C, 2'h2, 8'h94, 3'h0, 7'h06);
		check({31'h0, INT_HOLD_O}, 32'h0000_0001);
		do_req(32'h5000_0000, 2'h2, 8'h06, 3'h2, 7'h00);
		do_req(32'h6000_0000, 2'h2, 8'h06, 3'h0, 7'h62);
		do_req(32'h6000_0004, 2'h2, 8'h02, 3'h2, 7'h00);
		do_req(32'h6000_0008, 2'h2, 8'h04, 3'h1, 7'h00);
		do_req(32'h7000_0000, 2'h2, 8'h94, 3'h4, 7'h00);
		do_req(32'h7000_0000, 2'h2, 8'h35, 3'h0, 7'h02);
		axi_rd(OFF_FAULT_ADDR, 3'h1, 32'h6000_0008, RESP_OKAY);
		axi_rd(OFF_STATUS, 3'h1, 32'h0000_0901, RESP_OKAY);
		$display("Test attribute checks done");
		axi_wr(OFF_CTRL, 32'h0000_0001, 3'h1, RESP_OKAY);
		do_req(32'h5000_0010, 2'h2, 8'h00, 3'h0, 7'h06);
		do_req(32'h6000_0000, 2'h2, 8'h02, 3'h0, 7'h62);
		axi_wr(OFF_DEFAULT_ATTR, 32'h0000_0094, 3'h1, RESP_OKAY);
		do_req(32'h8000_0000, 2'h2, 8'h00, 3'h0, 7'h12);
		$display("Test without privilege extension done");
		conclude();
	end
endmodule
